/* verilog/nvs_regs.svh */
// Purpose: Opcodes, status bit positions and reset values of the SPI front end
// Assumes: Included by bare name from design files
// Notes:   Opcode values are plain defaults; change them here only
`ifndef NVS_REGS_SVH
`define NVS_REGS_SVH

// Instruction opcodes
`define NVS_OP_SET_WE   8'h06
`define NVS_OP_CLR_WE   8'h04
`define NVS_OP_STAT_RD  8'h05
`define NVS_OP_STAT_WR  8'h01
`define NVS_OP_MEM_RD   8'h03
`define NVS_OP_MEM_FRD  8'h0b
`define NVS_OP_MEM_WR   8'h02
`define NVS_OP_CLK_WR   8'h12
`define NVS_OP_SN_WR    8'hc2
`define NVS_OP_STORE    8'h3c
`define NVS_OP_RECALL   8'h60
`define NVS_OP_AS_ON    8'h59
`define NVS_OP_AS_OFF   8'h19

// Status bit positions
`define NVS_SB_RDY      0
`define NVS_SB_WE       1
`define NVS_SB_BG_LO    2
`define NVS_SB_BG_HI    3
`define NVS_SB_SNL      6
`define NVS_SB_ARM      7

// Status reset value
`define NVS_STAT_RST    8'h00

// Address bytes per memory frame, minus one
`define NVS_ADDR_LAST   2'h2

`endif

/* verilog/nvs_pkg.sv */
// Purpose: Shared types of the SPI front end
// Assumes: Nothing beyond the standard language
// Notes:   States are one-hot
package nvs_pkg;

   // Frame phase, one-hot
   typedef enum logic [7:0]
   {
      NVS_OPC   = 8'h01,  // Collecting opcode
      NVS_ADDR  = 8'h02,  // Collecting address bytes
      NVS_DUMMY = 8'h04,  // Fast read dummy byte
      NVS_RDATA = 8'h08,  // Memory data out
      NVS_WDATA = 8'h10,  // Memory data in
      NVS_SWR   = 8'h20,  // Status data in
      NVS_SRD   = 8'h40,  // Status data out
      NVS_SKIP  = 8'h80   // Ignore rest of frame
   } nvs_state_t;

endpackage

/* verilog/nvs_sclk_edge.sv */
// Purpose: Serial clock edge detection inside a selected frame
// Assumes: sclk and csN synchronous to clk
// Notes:   One pulse per serial clock edge
`timescale 1ns/1ps
module nvs_sclk_edge
   import nvs_pkg::*;
(
   // Clock and reset
   input  logic clk,
   input  logic srst,
   // Serial pins
   input  logic sclk,
   input  logic csN,
   // Edge pulses
   output logic rise,
   output logic fall
);

   // All state of this module
   typedef struct packed {
      logic sclkQ;  // Serial clock one cycle ago
   } nvs_edge_st_t;

   nvs_edge_st_t s;       // Current state
   nvs_edge_st_t next_s;  // Next state

   // Next state
   always_comb
   begin
      next_s       = s;
      next_s.sclkQ = sclk;
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Edges only count while selected
   assign rise = sclk & ~s.sclkQ & ~csN;
   assign fall = ~sclk & s.sclkQ & ~csN;

endmodule // nvs_sclk_edge

/* verilog/nvs_block_guard.sv */
// Purpose: Decode of the two block guard bits against an address
// Assumes: Address width of at least two bits
// Notes:   Purely combinational
`timescale 1ns/1ps
module nvs_block_guard
   import nvs_pkg::*;
#(
   parameter int AW = 17  // Array address width
)
(
   // Guard setting
   input  logic          guardHi,
   input  logic          guardLo,
   // Address under test
   input  logic [AW-1:0] addr,
   // Result
   output logic          locked
);

   // Quarter, half or whole array from the top
   always_comb
   begin
      unique case ({guardHi, guardLo})
         2'b00:   locked = 1'b0;
         2'b01:   locked = &addr[AW-1:AW-2];
         2'b10:   locked = addr[AW-1];
         default: locked = 1'b1;
      endcase
   end

endmodule // nvs_block_guard

/* verilog/nvs_spi_front.sv */
// Purpose: SPI slave front end for a 128K x 8 nonvolatile SRAM
// Assumes: SPI pins synchronous to clk; SCK high and low each >= 4 clk
// Notes:   Modes 0 and 3; array, store engine and clock sit outside
//
// Overview of operation
// - Write-enable latch cleared after reset
// - Write commands ignored while latch clear
// - Set-write-enable command sets the latch
// - Completed write commands clear the latch
// - Clear-write-enable acts on chip-select rise
// - Guard bits protect quarter, half or all
// - Guarded addresses are never written
// - Armed low guard pin refuses status writes
// - Disarmed guard pin is ignored
// - Guard pin change spares running status write
// - Memory opcodes refused during store or recall
// - Read data leaves MSB first on falling
// - Read burst increments and wraps to zero
// - Fast read adds one dummy byte
// - Chip-select rise ends any read cleanly
// - Write burst increments and wraps to zero
// - Guarded bytes skipped, address still advances
// - Status write alters only bits 2,3,6,7
`timescale 1ns/1ps
`include "nvs_regs.svh"
module nvs_spi_front
   import nvs_pkg::*;
#(
   parameter int AW = 17  // Array address width
)
(
   // Clock and reset
   input  logic          clk,
   input  logic          srst,
   // SPI pins
   input  logic          csN,
   input  logic          sclk,
   input  logic          mosi,
   output logic          miso,
   output logic          misoOe,
   // Guard pin and busy sources
   input  logic          writeGuardPinN,
   input  logic          hardwareStoreBusyPinN,
   input  logic          nvBusy,
   // Array read port
   output logic [AW-1:0] memRdAddr,
   output logic          memRdEn,
   input  logic [7:0]    memRdData,
   // Array write port
   output logic [AW-1:0] memWrAddr,
   output logic [7:0]    memWrData,
   output logic          memWrEn,
   // Nonvolatile engine requests
   output logic          storeReq,
   output logic          recallReq,
   output logic          autosaveOnReq,
   output logic          autosaveOffReq,
   // Status view
   output logic [7:0]    statusBits
);

   // All state of this module
   typedef struct packed {
      nvs_state_t    state;    // Frame phase
      logic [7:0]    sr;       // Input shift register
      logic [2:0]    bitCnt;   // Bits of current byte
      logic [1:0]    byteCnt;  // Address bytes taken
      logic [7:0]    op;       // Opcode of frame
      logic [AW-1:0] addr;     // Burst address
      logic [AW-1:0] wrAddr;   // Address of pending write
      logic [7:0]    wrData;   // Data of pending write
      logic [7:0]    rdByte;   // Byte fetched for output
      logic [7:0]    txSr;     // Output shift register
      logic          rdReq;    // Array read strobe
      logic          rdLat;    // Read data arrives now
      logic          wrReq;    // Array write strobe
      logic          we;       // Write-enable latch
      logic          bgLo;     // Block guard low bit
      logic          bgHi;     // Block guard high bit
      logic          arm;      // Pin guard arming bit
      logic          snl;      // Serial number lock
      logic          wrOk;     // Status write permitted
      logic          pend;     // Action due at frame end
      logic          miso;     // Output bit
      logic          oe;       // Output enable
      logic          storeReq;
      logic          recallReq;
      logic          asOnReq;
      logic          asOffReq;
   } nvs_core_st_t;

   localparam logic [7:0] STAT_RST = `NVS_STAT_RST;  // Status after reset

   // Reset value of the whole state
   localparam nvs_core_st_t CORE_RST = '{
      state:   NVS_OPC,
      we:      STAT_RST[`NVS_SB_WE],
      bgLo:    STAT_RST[`NVS_SB_BG_LO],
      bgHi:    STAT_RST[`NVS_SB_BG_HI],
      arm:     STAT_RST[`NVS_SB_ARM],
      snl:     STAT_RST[`NVS_SB_SNL],
      default: '0
   };

   nvs_core_st_t s;         // Current state
   nvs_core_st_t next_s;    // Next state
   logic         rise;      // Serial clock rising
   logic         fall;      // Serial clock falling
   logic         lockCur;   // Burst address guarded
   logic         busy;      // Store or recall running
   logic [7:0]   rxByte;    // Byte including new bit
   logic         byteEnd;   // Last bit of a byte
   logic [7:0]   outSrc;    // Byte to start sending
   logic [2:0]   guardBits; // Arm and guard status bits

   // Serial clock edges
   nvs_sclk_edge u_edge
   (
      .clk  (clk),
      .srst (srst),
      .sclk (sclk),
      .csN  (csN),
      .rise (rise),
      .fall (fall)
   );

   // Block guard against the burst address
   nvs_block_guard #(.AW(AW)) u_guard
   (
      .guardHi (s.bgHi),
      .guardLo (s.bgLo),
      .addr    (s.addr),
      .locked  (lockCur)
   );

   // Busy from nonvolatile engine or store pin
   assign busy    = nvBusy | ~hardwareStoreBusyPinN;
   // Sample data in on the rising edge
   assign rxByte  = {s.sr[6:0], mosi};
   assign byteEnd = rise & (s.bitCnt == 3'h7);
   assign outSrc  = (s.state == NVS_SRD) ? statusBits : s.rdByte;
   assign guardBits = {s.arm, s.bgHi, s.bgLo};

   // Status byte assembly, bits 4 and 5 read zero
   always_comb
   begin
      statusBits               = 8'h00;
      statusBits[`NVS_SB_RDY]  = busy;
      statusBits[`NVS_SB_WE]   = s.we;
      statusBits[`NVS_SB_BG_LO] = s.bgLo;
      statusBits[`NVS_SB_BG_HI] = s.bgHi;
      statusBits[`NVS_SB_SNL]  = s.snl;
      statusBits[`NVS_SB_ARM]  = s.arm;
   end

   // Frame decoder and datapath
   always_comb
   begin
      next_s           = s;
      // Strobes last one cycle
      next_s.rdReq     = 1'b0;
      next_s.wrReq     = 1'b0;
      next_s.storeReq  = 1'b0;
      next_s.recallReq = 1'b0;
      next_s.asOnReq   = 1'b0;
      next_s.asOffReq  = 1'b0;
      // Capture array data one cycle after the strobe
      next_s.rdLat     = s.rdReq;
      if (s.rdLat)
      begin
         next_s.rdByte = memRdData;
      end
      if (csN)
      begin
         // Deselected: end frame, back to standby
         next_s.state  = NVS_OPC;
         next_s.bitCnt = 3'h0;
         next_s.oe     = 1'b0;
         next_s.miso   = 1'b0;
         if (s.pend)
         begin
            // Completed write-class frame drops the latch
            next_s.we   = 1'b0;
            next_s.pend = 1'b0;
            // Engine requests fire at frame end
            next_s.storeReq  = (s.op == `NVS_OP_STORE);
            next_s.recallReq = (s.op == `NVS_OP_RECALL);
            next_s.asOnReq   = (s.op == `NVS_OP_AS_ON);
            next_s.asOffReq  = (s.op == `NVS_OP_AS_OFF);
         end
      end
      else
      begin
         if (rise)
         begin
            // Shift in one bit
            next_s.sr     = rxByte;
            next_s.bitCnt = s.bitCnt + 3'h1;
         end
         if (byteEnd)
         begin
            unique case (s.state)
               NVS_OPC:
               begin
                  next_s.op    = rxByte;
                  next_s.state = NVS_SKIP;
                  case (rxByte)
                     `NVS_OP_SET_WE:
                     begin
                        next_s.we = 1'b1;
                     end
                     `NVS_OP_CLR_WE:
                     begin
                        next_s.pend = 1'b1;
                     end
                     `NVS_OP_STAT_RD:
                     begin
                        next_s.state = NVS_SRD;
                     end
                     `NVS_OP_STAT_WR:
                     begin
                        // Without the latch the frame is ignored
                        if (s.we)
                        begin
                           next_s.state = NVS_SWR;
                           // Pin judged once, at opcode time
                           next_s.wrOk  = ~s.arm | writeGuardPinN;
                        end
                     end
                     `NVS_OP_MEM_RD, `NVS_OP_MEM_FRD:
                     begin
                        // Refused while store or recall runs
                        if (!busy)
                        begin
                           next_s.state   = NVS_ADDR;
                           next_s.byteCnt = 2'h0;
                        end
                     end
                     `NVS_OP_MEM_WR:
                     begin
                        if (s.we && !busy)
                        begin
                           next_s.state   = NVS_ADDR;
                           next_s.byteCnt = 2'h0;
                        end
                     end
                     `NVS_OP_CLK_WR, `NVS_OP_SN_WR, `NVS_OP_STORE,
                     `NVS_OP_RECALL, `NVS_OP_AS_ON, `NVS_OP_AS_OFF:
                     begin
                        // Accepted only with the latch set
                        next_s.pend = s.we;
                     end
                     default:
                     begin
                        // Unknown opcode: ignore frame
                        next_s.state = NVS_SKIP;
                     end
                  endcase
               end
               NVS_ADDR:
               begin
                  // Top bits of first byte fall off the register
                  next_s.addr    = AW'({s.addr, rxByte});
                  next_s.byteCnt = s.byteCnt + 2'h1;
                  if (s.byteCnt == `NVS_ADDR_LAST)
                  begin
                     if (s.op == `NVS_OP_MEM_WR)
                     begin
                        next_s.state = NVS_WDATA;
                     end
                     else if (s.op == `NVS_OP_MEM_FRD)
                     begin
                        next_s.state = NVS_DUMMY;
                     end
                     else
                     begin
                        next_s.state = NVS_RDATA;
                        next_s.rdReq = 1'b1;
                     end
                  end
               end
               NVS_DUMMY:
               begin
                  // Dummy byte done, fetch first byte
                  next_s.state = NVS_RDATA;
                  next_s.rdReq = 1'b1;
               end
               NVS_RDATA:
               begin
                  // Next address, wrapping at top; input ignored
                  next_s.addr  = s.addr + AW'(1);
                  next_s.rdReq = 1'b1;
               end
               NVS_WDATA:
               begin
                  // Guarded bytes dropped, address moves on
                  next_s.wrReq  = ~lockCur;
                  next_s.wrAddr = s.addr;
                  next_s.wrData = rxByte;
                  next_s.addr   = s.addr + AW'(1);
                  next_s.pend   = 1'b1;
               end
               NVS_SWR:
               begin
                  // Only guard, lock and arm bits can change
                  if (s.wrOk)
                  begin
                     next_s.bgLo = rxByte[`NVS_SB_BG_LO];
                     next_s.bgHi = rxByte[`NVS_SB_BG_HI];
                     next_s.arm  = rxByte[`NVS_SB_ARM];
                     next_s.snl  = s.snl | rxByte[`NVS_SB_SNL];
                  end
                  next_s.pend  = 1'b1;
                  next_s.state = NVS_SKIP;
               end
               NVS_SRD:
               begin
                  // Status repeats while selected
                  next_s.state = NVS_SRD;
               end
               NVS_SKIP:
               begin
                  // Wait for a fresh select
                  next_s.state = NVS_SKIP;
               end
            endcase
         end
         if (fall && (s.state == NVS_RDATA || s.state == NVS_SRD))
         begin
            // Drive out on the falling edge, MSB first
            next_s.oe = 1'b1;
            if (s.bitCnt == 3'h0)
            begin
               next_s.miso = outSrc[7];
               next_s.txSr = {outSrc[6:0], 1'b0};
            end
            else
            begin
               next_s.miso = s.txSr[7];
               next_s.txSr = {s.txSr[6:0], 1'b0};
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s <= CORE_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs straight from flops
   assign miso           = s.miso;
   assign misoOe         = s.oe;
   assign memRdAddr      = s.addr;
   assign memRdEn        = s.rdReq;
   assign memWrAddr      = s.wrAddr;
   assign memWrData      = s.wrData;
   assign memWrEn        = s.wrReq;
   assign storeReq       = s.storeReq;
   assign recallReq      = s.recallReq;
   assign autosaveOnReq  = s.asOnReq;
   assign autosaveOffReq = s.asOffReq;

   // Latch clear after reset
   property p_we_reset;
      @(posedge clk) srst |=> !s.we;
   endproperty
   a_we_reset: assert property (p_we_reset) else $error("latch set after reset");

   // Memory write phase only entered with the latch set
   property p_wr_needs_we;
      @(posedge clk) disable iff (srst)
      $rose(s.state == NVS_WDATA) |-> $past(s.we);
   endproperty
   a_wr_needs_we: assert property (p_wr_needs_we) else $error("write without latch");

   // Set command sets the latch next cycle
   property p_set_we;
      @(posedge clk) disable iff (srst)
      (!csN && byteEnd && s.state == NVS_OPC && rxByte == `NVS_OP_SET_WE) |=> s.we;
   endproperty
   a_set_we: assert property (p_set_we) else $error("latch not set");

   // Pending action clears the latch at deselect
   property p_pend_clear;
      @(posedge clk) disable iff (srst)
      ($rose(csN) && s.pend) |=> !s.we;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("latch kept");

   // No write strobe to a guarded address
   property p_guard_write;
      @(posedge clk) disable iff (srst)
      memWrEn |-> !$past(lockCur);
   endproperty
   a_guard_write: assert property (p_guard_write) else $error("guarded write");

   // Refused status write leaves bits alone
   property p_stat_refused;
      @(posedge clk) disable iff (srst)
      (!csN && byteEnd && s.state == NVS_SWR && !s.wrOk) |=> $stable(guardBits);
   endproperty
   a_stat_refused: assert property (p_stat_refused) else $error("status changed");

   // Memory read opcode while busy is skipped
   property p_busy_skip;
      @(posedge clk) disable iff (srst)
      (!csN && byteEnd && s.state == NVS_OPC && rxByte == `NVS_OP_MEM_RD && busy)
      |=> s.state == NVS_SKIP;
   endproperty
   a_busy_skip: assert property (p_busy_skip) else $error("read while busy");

   // Burst address wraps to zero
   property p_wrap;
      @(posedge clk) disable iff (srst)
      (!csN && byteEnd && s.state == NVS_RDATA && &s.addr) |=> s.addr == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap");

   // First bit of a byte is the fetched MSB
   property p_msb_first;
      @(posedge clk) disable iff (srst)
      (!csN && fall && s.state == NVS_RDATA && s.bitCnt == 3'h0) |=> miso == s.rdByte[7];
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("bad first bit");

   // Deselect ends output within one cycle and holds idle
   property p_cs_end;
      @(posedge clk) disable iff (srst)
      csN ##1 csN |-> (s.state == NVS_OPC && !misoOe);
   endproperty
   a_cs_end: assert property (p_cs_end) else $error("frame not ended");

   // Main scenarios
   c_mem_write: cover property (@(posedge clk) disable iff (srst) memWrEn);
   c_fast_read: cover property (@(posedge clk) disable iff (srst)
      s.op == `NVS_OP_MEM_FRD && s.state == NVS_RDATA && misoOe);
   c_stat_write: cover property (@(posedge clk) disable iff (srst)
      byteEnd && s.state == NVS_SWR && s.wrOk);
   c_store: cover property (@(posedge clk) disable iff (srst) storeReq);

endmodule // nvs_spi_front

/* testbench/nvs_host_model.sv */
// Purpose: SPI host model that drives the front end pins
// Assumes: Mode 0, four clk low and five clk high per serial clock bit
// Notes:   Data line toggles once deselected
`timescale 1ns/1ps
module nvs_host_model
(
   // Clock
   input  logic clk,
   // SPI pins
   output logic csN,
   output logic sclk,
   output logic mosi,
   input  logic miso
);
   // Idle pin levels
   initial
   begin
      csN  = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   // One byte MSB first, changed on fall, sampled on rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         @(negedge clk) mosi = tx[i];
         sclk = 1'b0;
         repeat (4) @(negedge clk);
         rx[i] = miso;
         sclk = 1'b1;
         repeat (4) @(negedge clk);
      end
   endtask

   // Whole frame of n bytes, taken from the top of tx
   task automatic frame(input int n, input logic [47:0] tx, output logic [47:0] rx);
      logic [7:0] r;
      rx = '0;
      @(negedge clk) csN = 1'b0;
      for (int k = 0; k < n; k++)
      begin
         xfer(tx[47-8*k -: 8], r);
         rx[47-8*k -: 8] = r;
      end
      @(negedge clk) sclk = 1'b0;
      repeat (4) @(negedge clk);
      csN  = 1'b1;
      mosi = ~mosi;
      repeat (4) @(negedge clk);
   endtask
endmodule // nvs_host_model

/* testbench/tb_nvs_spi_front.sv */
// Purpose: Self-checking bench of the SPI front end
// Assumes: Host model on the far side, array modelled here
// Notes:   Array byte is the low address byte xor 5a
`timescale 1ns/1ps
`include "nvs_regs.svh"
module tb_nvs_spi_front;
   logic        clk = 1'b0;
   logic        srst, csN, sclk, mosi, miso, misoOe, wgN, hsbN, nvBusy;
   logic [16:0] memRdAddr, memWrAddr, wrAddr;
   logic [7:0]  memWrData, statusBits, wrData;
   logic        memRdEn, memWrEn, storeReq;
   int          wrCnt = 0, rdCnt = 0, stCnt = 0, n0, cycles = 0;
   int          error_cnt = 0, samples_checked = 0;
   logic [47:0] rx;

   always #5 clk = ~clk;

   nvs_host_model host (.clk(clk), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso));
   nvs_spi_front dut (.clk(clk), .srst(srst), .csN(csN), .sclk(sclk), .mosi(mosi),
      .miso(miso), .misoOe(misoOe), .writeGuardPinN(wgN), .hardwareStoreBusyPinN(hsbN),
      .nvBusy(nvBusy), .memRdAddr(memRdAddr), .memRdEn(memRdEn),
      .memRdData(memRdAddr[7:0] ^ 8'h5a), .memWrAddr(memWrAddr), .memWrData(memWrData),
      .memWrEn(memWrEn), .storeReq(storeReq), .recallReq(), .autosaveOnReq(),
      .autosaveOffReq(), .statusBits(statusBits));

   // Strobe counters and timeout, sampled mid-cycle away from the launch edge
   always @(negedge clk)
   begin
      cycles++;
      if (memWrEn === 1'b1) wrCnt++;
      if (memWrEn === 1'b1) wrAddr = memWrAddr;
      if (memWrEn === 1'b1) wrData = memWrData;
      if (memRdEn === 1'b1) rdCnt++;
      if (storeReq === 1'b1) stCnt++;
      if (cycles == 30000)
      begin
         error_cnt++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results;
      if (error_cnt == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmd(input int n, input logic [47:0] tx);
      host.frame(n, tx, rx);
   endtask

   task automatic we_on;
      cmd(1, {`NVS_OP_SET_WE, 40'h0});
   endtask

   // Latch after reset, refusal, set and clear
   task automatic t_enable;
      check(statusBits, 8'h00);
      cmd(5, {`NVS_OP_MEM_WR, 24'h000010, 16'h1100});
      check(wrCnt, 0);
      we_on();
      check(statusBits[1], 1'b1);
      cmd(1, {`NVS_OP_CLR_WE, 40'h0});
      check(statusBits[1], 1'b0);
      we_on();
      cmd(4, {`NVS_OP_MEM_WR, 24'h000020, 16'h0});
      check(wrCnt, 0);
      check(statusBits[1], 1'b1);
   endtask

   // Burst across the top of the array
   task automatic t_burst;
      we_on();
      cmd(6, {`NVS_OP_MEM_WR, 24'h01ffff, 16'ha53c});
      check(wrCnt, 2);
      check(wrAddr, 17'h0);
      check(wrData, 8'h3c);
      check(statusBits[1], 1'b0);
   endtask

   // Guard bits, pin guard and status mask
   task automatic t_guard;
      we_on();
      cmd(2, {`NVS_OP_STAT_WR, 8'h07, 32'h0});
      check(statusBits, 8'h04);
      n0 = wrCnt;
      we_on();
      cmd(6, {`NVS_OP_MEM_WR, 24'h017fff, 16'h1122});
      check(wrCnt - n0, 1);
      check(wrAddr, 17'h17fff);
      check(wrData, 8'h11);
      we_on();
      cmd(2, {`NVS_OP_STAT_WR, 8'h84, 32'h0});
      we_on();
      // Pin drops during the data byte of an armed status write
      fork
         cmd(2, {`NVS_OP_STAT_WR, 8'h8c, 32'h0});
         begin
            repeat (100) @(negedge clk);
            wgN = 1'b0;
         end
      join
      check(statusBits, 8'h8c);
      we_on();
      cmd(2, {`NVS_OP_STAT_WR, 8'h08, 32'h0});
      check(statusBits, 8'h8c);
      wgN = 1'b1;
      we_on();
      cmd(2, {`NVS_OP_STAT_WR, 8'h04, 32'h0});
      check(statusBits, 8'h04);
      wgN = 1'b0;
      we_on();
      cmd(2, {`NVS_OP_STAT_WR, 8'h0c, 32'h0});
      check(statusBits, 8'h0c);
      host.frame(2, {`NVS_OP_STAT_RD, 40'h0}, rx);
      check(rx[39:32], 8'h0c);
      wgN = 1'b1;
      we_on();
      cmd(5, {`NVS_OP_MEM_WR, 24'h000000, 16'h3300});
      check(wrCnt - n0, 1);
   endtask

   // Normal read wrapping, fast read with dummy byte
   task automatic t_read;
      host.frame(6, {`NVS_OP_MEM_RD, 24'h01ffff, 16'h0}, rx);
      check(rx[15:0], 16'ha55a);
      check(misoOe, 1'b0);
      host.frame(6, {`NVS_OP_MEM_FRD, 24'h000012, 16'h0}, rx);
      check(rx[7:0], 8'h48);
   endtask

   // No array read while busy
   task automatic t_busy;
      nvBusy = 1'b1;
      n0 = rdCnt;
      cmd(6, {`NVS_OP_MEM_RD, 24'h000001, 16'h0});
      check(rdCnt - n0, 0);
      nvBusy = 1'b0;
      hsbN = 1'b0;
      check(statusBits[0], 1'b1);
      cmd(6, {`NVS_OP_MEM_RD, 24'h000001, 16'h0});
      check(rdCnt - n0, 0);
      hsbN = 1'b1;
   endtask

   // Store request needs the latch and then drops it
   task automatic t_nv;
      cmd(1, {`NVS_OP_STORE, 40'h0});
      check(stCnt, 0);
      we_on();
      cmd(1, {`NVS_OP_STORE, 40'h0});
      check(stCnt, 1);
      check(statusBits[1], 1'b0);
   endtask

   initial
   begin
      srst   = 1'b1;
      wgN    = 1'b1;
      hsbN   = 1'b1;
      nvBusy = 1'b0;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      t_enable();
      t_burst();
      t_guard();
      t_read();
      t_busy();
      t_nv();
      results();
   end
endmodule // tb_nvs_spi_front
